/* File: core/eqap_defs.vh */
`ifndef EQAP_DEFS_VH
`define EQAP_DEFS_VH
`define EQAP_ADDR_CTL        8'h42
`define EQAP_ADDR_THOLD      8'h43
`define EQAP_ADDR_RSVD_LO    8'h44
`define EQAP_ADDR_RSVD_HI    8'h4B
`define EQAP_ADDR_PORT_SEL   8'h4C
`define EQAP_CTL_ERR_SEL_HI  6
`define EQAP_CTL_ERR_SEL_LO  4
`define EQAP_CTL_FILT_ORDER  3
`define EQAP_CTL_TWO_STEP    2
`define EQAP_CTL_LOOP_ORDER  1
`define EQAP_CTL_FILT_EN     0
`define EQAP_RST_ERR_SEL     3'h7
`define EQAP_RST_FILT_ORDER  1'h0
`define EQAP_RST_TWO_STEP    1'h1
`define EQAP_RST_LOOP_ORDER  1'h0
`define EQAP_RST_FILT_EN     1'h0
`define EQAP_RST_THOLD       8'h01
`define EQAP_RST_LOCAL_SEL   1'h0
`define EQAP_SEL_PHYS_HI     7
`define EQAP_SEL_PHYS_LO     6
`define EQAP_SEL_READ_PORT   2
`endif

/* File: core/eqap_seq.v */
`timescale 1ns/1ps
`include "eqap_defs.vh"
module eqap_seq #(
    parameter EQ_MAX   = 4'hF,
    parameter FILT_MAX = 4'hE
) (
    input  wire        clk_sys_in,
    input  wire        rst_in,
    input  wire        adapt_en_in,
    input  wire        two_step_in,
    input  wire        loop_order_in,
    input  wire        filt_en_in,
    input  wire [7:0]  limit_in,
    input  wire [15:0] relock_in,
    input  wire        err_in,
    input  wire        lock_in,
    output reg  [3:0]  eq_code_out,
    output reg  [3:0]  filt_code_out,
    output reg         valid_out
);
    localparam S_IDLE  = 4'h1;
    localparam S_WAIT  = 4'h2;
    localparam S_CHECK = 4'h4;
    localparam S_MON   = 4'h8;

    reg [3:0]  state_q;
    reg [15:0] tmr_q;
    reg [8:0]  errs_q;
    wire [15:0] half = {1'b0, relock_in[15:1]};
    wire [15:0] full = relock_in;

    function [3:0] wrap_inc;
        input [3:0] v;
        input [3:0] m;
        begin
            wrap_inc = (v == m) ? 4'h0 : v + 4'h1;
        end
    endfunction

    // Advances to the next setting; the inner loop carries into the outer
    task advance;
        begin
            tmr_q  <= 16'h0000;
            errs_q <= 9'h000;
            state_q <= S_WAIT;
            valid_out <= 1'b0;
            if (!filt_en_in)
                eq_code_out <= wrap_inc(eq_code_out, EQ_MAX);
            else if (!loop_order_in)
            begin
                eq_code_out <= wrap_inc(eq_code_out, EQ_MAX);
                if (eq_code_out == EQ_MAX)
                    filt_code_out <= wrap_inc(filt_code_out, FILT_MAX);
            end
            else
            begin
                filt_code_out <= wrap_inc(filt_code_out, FILT_MAX);
                if (filt_code_out == FILT_MAX)
                    eq_code_out <= wrap_inc(eq_code_out, EQ_MAX);
            end
        end
    endtask

    always @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            state_q <= S_IDLE;
            tmr_q <= 16'h0000;
            errs_q <= 9'h000;
            eq_code_out <= 4'h0;
            filt_code_out <= 4'h0;
            valid_out <= 1'b0;
        end
        else if (!adapt_en_in)
        begin
            state_q <= S_IDLE;
            tmr_q <= 16'h0000;
            errs_q <= 9'h000;
            valid_out <= 1'b0;
        end
        else
        begin
            case (state_q)
                S_IDLE:
                begin
                    state_q <= S_WAIT;
                    tmr_q <= 16'h0000;
                end
                S_WAIT:
                begin
                    tmr_q <= tmr_q + 16'h0001;
                    if (two_step_in && tmr_q + 16'h0001 >= half)
                    begin
                        tmr_q <= 16'h0000;
                        errs_q <= 9'h000;
                        state_q <= S_CHECK;
                    end
                    else if (!two_step_in && tmr_q + 16'h0001 >= full)
                    begin
                        if (lock_in)
                        begin
                            tmr_q <= 16'h0000;
                            valid_out <= 1'b1;
                            state_q <= S_MON;
                        end
                        else
                            advance;
                    end
                end
                S_CHECK:
                begin
                    tmr_q <= tmr_q + 16'h0001;
                    if (err_in)
                        advance;
                    else if (tmr_q + 16'h0001 >= half)
                    begin
                        tmr_q <= 16'h0000;
                        valid_out <= 1'b1;
                        state_q <= S_MON;
                    end
                end
                S_MON:
                begin
                    if (errs_q + {8'h00, err_in} > {1'b0, limit_in})
                        advance;
                    else if (tmr_q + 16'h0001 >= half)
                    begin
                        tmr_q <= 16'h0000;
                        errs_q <= 9'h000;
                    end
                    else
                    begin
                        tmr_q <= tmr_q + 16'h0001;
                        errs_q <= errs_q + {8'h00, err_in};
                    end
                end
                default:
                    state_q <= S_IDLE;
            endcase
        end
    end
endmodule // eqap_seq

/* File: core/eqap_ctl.v */
`timescale 1ns/1ps
`include "eqap_defs.vh"
module eqap_ctl #(
    parameter EQ_MAX   = 4'hF,
    parameter FILT_MAX = 4'hE
) (
    input  wire        clk_sys_in,
    input  wire        rst_in,
    input  wire        reg_wr_in,
    input  wire        reg_rd_in,
    input  wire [7:0]  reg_addr_in,
    input  wire [7:0]  reg_wdata_in,
    input  wire        reg_via_bcc_in,
    input  wire        reg_bcc_port_in,
    input  wire [7:0]  page_rdata_p0_in,
    input  wire [7:0]  page_rdata_p1_in,
    input  wire        adapt_en_in,
    input  wire [15:0] eq_relock_period_in,
    input  wire        err_clk_in,
    input  wire        err_seq_in,
    input  wire        err_par_in,
    input  wire        lock_in,
    output reg  [7:0]  reg_rdata_out,
    output reg         reg_rvalid_out,
    output wire [3:0]  eq_code_out,
    output wire [3:0]  filt_code_out,
    output wire        eq_valid_out,
    output reg         filt_order_out
);
    reg [2:0] eq_error_select_q;
    reg       two_step_validate_en_q;
    reg       eq_loop_order_q;
    reg       delay_filter_in_eq_en_q;
    reg [7:0] eq_error_limit_q;
    reg       local_sel_q;
    reg [1:0] bcc_sel_q;
    reg [3:0] err_s1_q;
    reg [3:0] err_s2_q;

    wire      act_sel;
    wire [1:0] physical_port_id;
    wire      err_any;

    assign act_sel = reg_via_bcc_in ? bcc_sel_q[reg_bcc_port_in]
                                    : local_sel_q;
    assign physical_port_id = reg_via_bcc_in ? {1'b0, reg_bcc_port_in}
                                             : 2'b00;
    assign err_any = |(eq_error_select_q & err_s2_q[2:0]);

    // Receiver status is asynchronous here
    always @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            err_s1_q <= 4'h0;
            err_s2_q <= 4'h0;
        end
        else
        begin
            err_s1_q <= {lock_in, err_clk_in, err_seq_in, err_par_in};
            err_s2_q <= err_s1_q;
        end
    end

    always @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            eq_error_select_q <= `EQAP_RST_ERR_SEL;
            filt_order_out <= `EQAP_RST_FILT_ORDER;
            two_step_validate_en_q <= `EQAP_RST_TWO_STEP;
            eq_loop_order_q <= `EQAP_RST_LOOP_ORDER;
            delay_filter_in_eq_en_q <= `EQAP_RST_FILT_EN;
            eq_error_limit_q <= `EQAP_RST_THOLD;
            local_sel_q <= `EQAP_RST_LOCAL_SEL;
            // Back channel copies start at their own port number
            bcc_sel_q <= 2'b10;
        end
        else if (reg_wr_in)
        begin
            if (reg_addr_in == `EQAP_ADDR_CTL)
            begin
                eq_error_select_q <=
                    reg_wdata_in[`EQAP_CTL_ERR_SEL_HI:`EQAP_CTL_ERR_SEL_LO];
                filt_order_out <= reg_wdata_in[`EQAP_CTL_FILT_ORDER];
                two_step_validate_en_q <= reg_wdata_in[`EQAP_CTL_TWO_STEP];
                eq_loop_order_q <= reg_wdata_in[`EQAP_CTL_LOOP_ORDER];
                delay_filter_in_eq_en_q <= reg_wdata_in[`EQAP_CTL_FILT_EN];
            end
            // Limit register; zero is not blocked
            else if (reg_addr_in == `EQAP_ADDR_THOLD)
                eq_error_limit_q <= reg_wdata_in;
            // Only the selector bit is stored
            else if (reg_addr_in == `EQAP_ADDR_PORT_SEL)
            begin
                if (reg_via_bcc_in)
                    bcc_sel_q[reg_bcc_port_in] <=
                        reg_wdata_in[`EQAP_SEL_READ_PORT];
                else
                    local_sel_q <= reg_wdata_in[`EQAP_SEL_READ_PORT];
            end
        end
    end

    always @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            reg_rdata_out <= 8'h00;
            reg_rvalid_out <= 1'b0;
        end
        else
        begin
            reg_rvalid_out <= reg_rd_in;
            if (reg_rd_in)
            begin
                if (reg_addr_in == `EQAP_ADDR_CTL)
                    reg_rdata_out <= {1'b0, eq_error_select_q,
                                      filt_order_out,
                                      two_step_validate_en_q,
                                      eq_loop_order_q,
                                      delay_filter_in_eq_en_q};
                else if (reg_addr_in == `EQAP_ADDR_THOLD)
                    reg_rdata_out <= eq_error_limit_q;
                else if (reg_addr_in >= `EQAP_ADDR_RSVD_LO &&
                         reg_addr_in <= `EQAP_ADDR_RSVD_HI)
                    reg_rdata_out <= 8'h00;
                else if (reg_addr_in == `EQAP_ADDR_PORT_SEL)
                    reg_rdata_out <= {physical_port_id, 3'b000,
                                      act_sel, 2'b00};
                else if (act_sel)
                    reg_rdata_out <= page_rdata_p1_in;
                else
                    reg_rdata_out <= page_rdata_p0_in;
            end
        end
    end

    eqap_seq #(
        .EQ_MAX   (EQ_MAX),
        .FILT_MAX (FILT_MAX)
    ) u_seq (
        .clk_sys_in    (clk_sys_in),
        .rst_in        (rst_in),
        .adapt_en_in   (adapt_en_in),
        .two_step_in   (two_step_validate_en_q),
        .loop_order_in (eq_loop_order_q),
        .filt_en_in    (delay_filter_in_eq_en_q),
        .limit_in      (eq_error_limit_q),
        .relock_in     (eq_relock_period_in),
        .err_in        (err_any),
        .lock_in       (err_s2_q[3]),
        .eq_code_out   (eq_code_out),
        .filt_code_out (filt_code_out),
        .valid_out     (eq_valid_out)
    );
endmodule // eqap_ctl

/* File: dv/eqap_page_model.sv */
`timescale 1ns/1ps
module eqap_page_model (
    input  wire [7:0] addr_in,
    output wire [7:0] p0_out,
    output wire [7:0] p1_out
);
    // Different data per port, so a wrong steer cannot pass
    assign p0_out = addr_in ^ 8'hA5;
    assign p1_out = ~addr_in;
endmodule // eqap_page_model

/* File: dv/eqap_ctl_props.sv */
`timescale 1ns/1ps
module eqap_ctl_props (
    input wire       clk_sys_in,
    input wire       rst_in,
    input wire       reg_wr_in,
    input wire       reg_rd_in,
    input wire [7:0] reg_addr_in,
    input wire [7:0] reg_wdata_in,
    input wire       reg_via_bcc_in,
    input wire       reg_bcc_port_in,
    input wire [7:0] page_rdata_p0_in,
    input wire [7:0] page_rdata_p1_in,
    input wire [7:0] reg_rdata_out,
    input wire       reg_rvalid_out,
    input wire [3:0] eq_code_out,
    input wire [3:0] filt_code_out,
    input wire       eq_valid_out
);
    reg [7:0] ctl_q;
    reg       sel_q;
    always @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            ctl_q <= 8'h74;
            sel_q <= 1'b0;
        end
        else if (reg_wr_in && reg_addr_in == 8'h42)
            ctl_q <= {1'b0, reg_wdata_in[6:0]};
        else if (reg_wr_in && reg_addr_in == 8'h4C && !reg_via_bcc_in)
            sel_q <= reg_wdata_in[2];
    end
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    sequence sel_rd;
        reg_rd_in && reg_addr_in == 8'h4C;
    endsequence
    sequence page_rd;
        reg_rd_in && !reg_via_bcc_in && reg_addr_in > 8'h4C;
    endsequence
    read_answer_a:
        assert property (reg_rd_in |=> reg_rvalid_out) else $error("no rvalid");
    read_hold_a:
        assert property (!reg_rd_in |=> $stable(reg_rdata_out) && !reg_rvalid_out)
        else $error("rdata moved");
    ctl_readback_a:
        assert property (reg_rd_in && reg_addr_in == 8'h42 |=>
            reg_rdata_out == $past(ctl_q)) else $error("ctl read");
    sel_rsvd_a:
        assert property (sel_rd |=> reg_rdata_out[5:3] == 3'h0 &&
            reg_rdata_out[1:0] == 2'h0) else $error("reserved bits");
    local_port_a:
        assert property (sel_rd ##0 !reg_via_bcc_in |=> reg_rdata_out[7:6]
            == 2'h0 && reg_rdata_out[2] == $past(sel_q)) else $error("local");
    remote_port_a:
        assert property (sel_rd ##0 reg_via_bcc_in |=> reg_rdata_out[7:6]
            == {1'b0, $past(reg_bcc_port_in)}) else $error("remote port");
    page_steer_a:
        assert property (page_rd |=> reg_rdata_out == ($past(sel_q) ?
            $past(page_rdata_p1_in) : $past(page_rdata_p0_in)))
        else $error("page steer");
    filt_fixed_a:
        assert property (!ctl_q[0] && !$past(ctl_q[0]) |=>
            $stable(filt_code_out)) else $error("filter moved");
    advance_drop_a:
        assert property ($changed({eq_code_out, filt_code_out}) |->
            !eq_valid_out) else $error("valid on advance");
endmodule // eqap_ctl_props
bind eqap_ctl eqap_ctl_props u_props (.clk_sys_in, .rst_in, .reg_wr_in,
    .reg_rd_in, .reg_addr_in, .reg_wdata_in, .reg_via_bcc_in,
    .reg_bcc_port_in, .page_rdata_p0_in, .page_rdata_p1_in,
    .reg_rdata_out, .reg_rvalid_out, .eq_code_out, .filt_code_out,
    .eq_valid_out);

/* File: dv/eq_adapt_ctl_port_select_test.sv */
`timescale 1ns/1ps
module eq_adapt_ctl_port_select_test;
    reg        clk = 1'b0;
    reg        rst = 1'b1;
    reg        wr = 1'b0;
    reg        rdq = 1'b0;
    reg  [7:0] addr = 8'h00;
    reg  [7:0] wdata = 8'h00;
    reg        bcc = 1'b0;
    reg        port = 1'b0;
    reg        adapt = 1'b0;
    reg        err = 1'b0;
    reg        lock = 1'b1;
    wire [7:0] p0, p1, rdata;
    wire       rvalid, valid, forder;
    wire [3:0] eq, filt;
    integer    miscompares = 0;
    integer    check_count = 0;
    always #2.5 clk = ~clk;
    eqap_page_model pages (.addr_in(addr), .p0_out(p0), .p1_out(p1));
    // Error lines share one driver so the select field covers all three
    eqap_ctl uut (.clk_sys_in(clk), .rst_in(rst), .reg_wr_in(wr),
        .reg_rd_in(rdq), .reg_addr_in(addr), .reg_wdata_in(wdata),
        .reg_via_bcc_in(bcc), .reg_bcc_port_in(port),
        .page_rdata_p0_in(p0), .page_rdata_p1_in(p1), .adapt_en_in(adapt),
        .eq_relock_period_in(16'h0008), .err_clk_in(err), .err_seq_in(err),
        .err_par_in(err), .lock_in(lock), .reg_rdata_out(rdata),
        .reg_rvalid_out(rvalid), .eq_code_out(eq), .filt_code_out(filt),
        .eq_valid_out(valid), .filt_order_out(forder));
    task tally_and_finish;
    begin
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    end
    endtask
    task cmp(input [63:0] name, input [7:0] exp, input [7:0] got);
    begin
        check_count = check_count + 1;
        if (got !== exp)
        begin
            miscompares = miscompares + 1;
            $display("mismatch %0s exp %h got %h", name, exp, got);
        end
    end
    endtask
    task step;
    begin
        @(posedge clk);
        #1;
    end
    endtask
    task wr_reg(input [7:0] a, input [7:0] d);
    begin
        addr = a;
        wdata = d;
        wr = 1'b1;
        step;
        wr = 1'b0;
        step;
    end
    endtask
    task rd_reg(input [7:0] a, input [7:0] exp);
    begin
        addr = a;
        rdq = 1'b1;
        step;
        rdq = 1'b0;
        cmp("rdata", exp, rdata);
        cmp("rvalid", 8'h01, {7'h00, rvalid});
        step;
    end
    endtask
    // Mode 0 waits for a setting change, mode 1 for acceptance
    task wait_for(input integer mode);
        reg [7:0] start;
        integer   i;
    begin
        start = {eq, filt};
        i = 0;
        while ((mode ? valid !== 1'b1 : {eq, filt} === start) && i < 400)
        begin
            step;
            i = i + 1;
        end
        if (i == 400)
        begin
            miscompares = miscompares + 1;
            tally_and_finish;
        end
    end
    endtask
    task restart(input [7:0] ctl);
    begin
        adapt = 1'b0;
        wr_reg(8'h42, ctl);
        lock = 1'b0;
        adapt = 1'b1;
        wait_for(0);
    end
    endtask
    initial
    begin
        repeat (10) @(posedge clk);
        #1;
        rst = 1'b0;
        rd_reg(8'h42, 8'h74);
        rd_reg(8'h43, 8'h01);
        rd_reg(8'h4C, 8'h00);
        wr_reg(8'h42, 8'hFF);
        rd_reg(8'h42, 8'h7F);
        cmp("forder", 8'h01, {7'h00, forder});
        wr_reg(8'h43, 8'h02);
        rd_reg(8'h43, 8'h02);
        wr_reg(8'h44, 8'hFF);
        rd_reg(8'h44, 8'h00);
        wr_reg(8'h4B, 8'hFF);
        rd_reg(8'h4B, 8'h00);
        wr_reg(8'h4C, 8'hFF);
        rd_reg(8'h4C, 8'h04);
        rd_reg(8'h50, 8'hAF);
        wr_reg(8'h4C, 8'h00);
        rd_reg(8'h50, 8'hF5);
        bcc = 1'b1;
        port = 1'b1;
        rd_reg(8'h4C, 8'h44);
        rd_reg(8'h50, 8'hAF);
        port = 1'b0;
        rd_reg(8'h4C, 8'h00);
        bcc = 1'b0;
        wr_reg(8'h42, 8'h74);
        adapt = 1'b1;
        wait_for(1);
        cmp("codes", 8'h00, {eq, filt});
        err = 1'b1;
        wait_for(0);
        err = 1'b0;
        cmp("codes", 8'h10, {eq, filt});
        wait_for(1);
        wr_reg(8'h42, 8'h04);
        err = 1'b1;
        repeat (40) step;
        err = 1'b0;
        cmp("held", 8'h11, {eq, 3'h0, valid});
        cmp("heldf", 8'h00, {4'h0, filt});
        restart(8'h70);
        cmp("codes", 8'h20, {eq, filt});
        lock = 1'b1;
        wait_for(1);
        restart(8'h73);
        cmp("codes", 8'h21, {eq, filt});
        tally_and_finish;
    end
endmodule // eq_adapt_ctl_port_select_test
